// ### design/mdp_pkg.sv
// constants, register map and field layout for the drive protection configuration
package mdp_pkg;
    localparam int          NUM_REGS        = 10;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    // word addresses of the configuration registers and the status word
    localparam logic [7:0]  ADDR_STARTUP    = 8'h0B;
    localparam logic [7:0]  ADDR_OBSERVER   = 8'h0C;
    localparam logic [7:0]  ADDR_SOFTDT     = 8'h0F;
    localparam logic [7:0]  ADDR_OCACCEL    = 8'h10;
    localparam logic [7:0]  ADDR_SPEED      = 8'h11;
    localparam logic [7:0]  ADDR_SLEW       = 8'h12;
    localparam logic [7:0]  ADDR_CISS       = 8'h13;
    localparam logic [7:0]  ADDR_SHUNT      = 8'h14;
    localparam logic [7:0]  ADDR_STANDBY    = 8'h15;
    localparam logic [7:0]  ADDR_BRAKEMISC  = 8'h16;
    localparam logic [7:0]  ADDR_STATUS     = 8'h7F;
    localparam logic [7:0]  REG_ADDR [NUM_REGS] = '{8'h0B, 8'h0C, 8'h0F, 8'h10, 8'h11,
                                                    8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
    // storage index of each register the logic decodes
    localparam int          IDX_STARTUP     = 0;
    localparam int          IDX_OBSERVER    = 1;
    localparam int          IDX_SOFTDT      = 2;
    localparam int          IDX_OCACCEL     = 3;
    localparam int          IDX_SPEED       = 4;
    localparam int          IDX_SHUNT       = 7;
    localparam int          IDX_BRAKEMISC   = 9;
    localparam logic [15:0] CFG_RESET       = 16'h0000;
    // field positions
    localparam int          BIT_DIRECT_ADV  = 5;
    localparam int          BIT_LIMIT_EN    = 7;
    localparam int          BIT_TUNE_WIN    = 15;
    localparam int          IND_LSB         = 8;
    localparam int          IND_W           = 5;
    localparam int          SHUNT_LSB       = 8;
    localparam int          SHUNT_W         = 8;
    localparam int          BIT_SOFT_LONG   = 9;
    localparam int          BIT_DT_COMP     = 12;
    localparam int          BRAKE_LSB       = 14;
    localparam int          LOCK_LSB        = 2;
    localparam int          BIT_OC_AUTO     = 3;
    localparam int          BLANK_LSB       = 4;
    localparam int          BIT_SPD_REG     = 9;
    localparam int          SPD_W           = 9;
    localparam int          STAT_LSB        = 12;
    // timing and startup lock thresholds
    localparam longint      CLK_HZ          = 100_000_000;
    localparam int          CLK_NS          = 10;
    localparam longint      SOFT_SHORT_S    = 1;
    localparam longint      SOFT_LONG_S     = 4;
    localparam longint      OC_AUTO_S       = 5;
    localparam int          SOFT_SHORT_CYC  = int'(SOFT_SHORT_S * CLK_HZ);
    localparam int          SOFT_LONG_CYC   = int'(SOFT_LONG_S * CLK_HZ);
    localparam int          OC_AUTO_CYC     = int'(OC_AUTO_S * CLK_HZ);
    localparam int          TMR_W           = 29;
    localparam int          BLANK1_NS       = 320;
    localparam int          BLANK2_NS       = 640;
    localparam int          BLANK3_NS       = 1280;
    localparam logic [7:0]  BLANK1_CYC      = 8'((BLANK1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  BLANK2_CYC      = 8'((BLANK2_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  BLANK3_CYC      = 8'((BLANK3_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  LOCK_THR1       = 8'h05;
    localparam logic [7:0]  LOCK_THR2       = 8'h09;
    localparam logic [7:0]  LOCK_THR3       = 8'h0D;
endpackage

// ### design/mdp_top.sv
// configuration decode and protection timing for the motor drive
`timescale 1ns/10ps
module mdp_top
    import mdp_pkg::*;
#(
    parameter int SOFT_SHORT = SOFT_SHORT_CYC,   // one-second ramp cap in cycles
    parameter int SOFT_LONG  = SOFT_LONG_CYC,    // four-second ramp cap in cycles
    parameter int OC_AUTO    = OC_AUTO_CYC       // automatic fault clear delay
) (
    input  wire logic              sys_clk_i,          // 100 MHz clock
    input  wire logic              reset_i,            // sync reset, high
    input  wire logic [ADDR_W-1:0] reg_addr_i,         // register word address
    input  wire logic [DATA_W-1:0] reg_wdata_i,        // register write data
    input  wire logic              reg_we_i,           // write strobe
    input  wire logic              reg_re_i,           // read strobe
    output logic      [DATA_W-1:0] reg_rdata_o,        // read data, next cycle
    output logic                   reg_rvalid_o,       // read data valid pulse
    output logic                   advance_direct_o,   // advance angle taken directly
    output logic      [IND_W-1:0]  advance_angle_o,    // advance angle, degrees
    output logic      [SHUNT_W-1:0] shunt_code_o,      // shunt code, mohm x 3.7
    input  wire logic              over_limit_i,       // current above limit
    output logic                   current_limit_o,    // limiting active
    output logic                   tuning_window_o,    // inductance tuning open
    input  wire logic              soft_off_start_i,   // begin soft shutdown
    input  wire logic              soft_off_done_i,    // ramp reached zero
    output logic                   ramp_active_o,      // soft shutdown ramping
    output logic                   ramp_timeout_o,     // ramp cap hit, pulse
    output logic                   deadtime_comp_o,    // dead-time compensation on
    output logic      [3:0]        brake_mult_o,       // brake limit x rated current
    input  wire logic              gate_switch_i,      // phase output switched
    input  wire logic              oc_detect_i,        // raw over-current comparator
    input  wire logic              restart_i,          // motor restart pulse
    output logic                   blank_active_o,     // over-current blanked
    output logic                   oc_fault_o,         // over-current fault latched
    input  wire logic              startup_i,          // startup phase
    input  wire logic [7:0]        angle_err_i,        // angle error, degrees
    output logic                   lock_o,             // startup lock latched
    input  wire logic [SPD_W-1:0]  spd_pin_i,          // speed demand from pin
    output logic      [SPD_W-1:0]  speed_demand_o      // selected speed demand
);
    logic [DATA_W-1:0] cfg_r [NUM_REGS];
    logic [TMR_W-1:0]  ramp_cnt_r;
    logic [TMR_W-1:0]  ramp_max;
    logic [TMR_W-1:0]  oc_cnt_r;
    logic [7:0]        blank_cnt_r;
    logic [7:0]        blank_len;
    logic [7:0]        lock_thr;
    logic [1:0]        blank_code;
    logic [1:0]        lock_code;
    logic              oc_hit;
    logic              oc_auto_clr;
    logic              lock_hit;

    // register storage, writes act at once
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (reset_i) begin
                cfg_r[i] <= CFG_RESET;
            end else if (reg_we_i && reg_addr_i == REG_ADDR[i]) begin
                cfg_r[i] <= reg_wdata_i;
            end
        end
    end

    // readback, status word shows live state
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_re_i;
            if (reg_re_i) begin
                reg_rdata_o <= '0;
                if (reg_addr_i == ADDR_STATUS) begin
                    reg_rdata_o[STAT_LSB +: 4] <= {oc_fault_o, lock_o, ramp_active_o,
                                                   blank_active_o};
                end
                for (int i = 0; i < NUM_REGS; i++) begin
                    if (reg_addr_i == REG_ADDR[i]) begin
                        reg_rdata_o <= cfg_r[i];
                    end
                end
            end
        end
    end

    assign advance_direct_o = cfg_r[IDX_STARTUP][BIT_DIRECT_ADV];
    assign advance_angle_o  = cfg_r[IDX_OBSERVER][IND_LSB +: IND_W];
    assign shunt_code_o     = cfg_r[IDX_SHUNT][SHUNT_LSB +: SHUNT_W];
    assign current_limit_o  = cfg_r[IDX_STARTUP][BIT_LIMIT_EN] & over_limit_i;
    assign tuning_window_o  = cfg_r[IDX_OBSERVER][BIT_TUNE_WIN];
    assign deadtime_comp_o  = cfg_r[IDX_BRAKEMISC][BIT_DT_COMP];
    assign brake_mult_o     = 4'h1 << cfg_r[IDX_SOFTDT][BRAKE_LSB +: 2];

    // soft shutdown ramp with duration cap
    assign ramp_max = cfg_r[IDX_BRAKEMISC][BIT_SOFT_LONG] ? TMR_W'(SOFT_LONG)
                                                         : TMR_W'(SOFT_SHORT);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ramp_active_o  <= 1'b0;
            ramp_cnt_r     <= '0;
            ramp_timeout_o <= 1'b0;
        end else begin
            ramp_timeout_o <= 1'b0;
            if (!ramp_active_o) begin
                ramp_active_o <= soft_off_start_i;
                ramp_cnt_r    <= '0;
            end else if (soft_off_done_i) begin
                ramp_active_o <= 1'b0;
            end else if (ramp_cnt_r >= ramp_max - TMR_W'(1)) begin
                ramp_active_o  <= 1'b0;
                ramp_timeout_o <= 1'b1;
            end else begin
                ramp_cnt_r <= ramp_cnt_r + TMR_W'(1);
            end
        end
    end

    // over-current blanking after each output switch
    assign blank_code = cfg_r[IDX_OCACCEL][BLANK_LSB +: 2];
    always_comb begin
        case (blank_code)
            2'b01:   blank_len = BLANK1_CYC;
            2'b10:   blank_len = BLANK2_CYC;
            2'b11:   blank_len = BLANK3_CYC;
            default: blank_len = 8'h00;
        endcase
    end
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            blank_cnt_r <= 8'h00;
        end else if (gate_switch_i) begin
            blank_cnt_r <= blank_len;
        end else if (blank_cnt_r != 8'h00) begin
            blank_cnt_r <= blank_cnt_r - 8'h01;
        end
    end
    assign blank_active_o = (blank_cnt_r != 8'h00);
    assign oc_hit         = oc_detect_i & ~blank_active_o & ~gate_switch_i;

    // fault latch, a new hit wins over any clear
    assign oc_auto_clr = cfg_r[IDX_OCACCEL][BIT_OC_AUTO] &&
                         oc_cnt_r >= TMR_W'(OC_AUTO) - TMR_W'(1);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            oc_fault_o <= 1'b0;
            oc_cnt_r   <= '0;
        end else if (oc_hit) begin
            oc_fault_o <= 1'b1;
            oc_cnt_r   <= '0;
        end else if (oc_fault_o) begin
            if (cfg_r[IDX_OCACCEL][BIT_OC_AUTO] ? oc_auto_clr : restart_i) begin
                oc_fault_o <= 1'b0;
                oc_cnt_r   <= '0;
            end else if (cfg_r[IDX_OCACCEL][BIT_OC_AUTO]) begin
                oc_cnt_r <= oc_cnt_r + TMR_W'(1);
            end
        end
    end

    // startup angle-error lock, cleared by restart
    assign lock_code = cfg_r[IDX_SOFTDT][LOCK_LSB +: 2];
    always_comb begin
        case (lock_code)
            2'b01:   lock_thr = LOCK_THR1;
            2'b10:   lock_thr = LOCK_THR2;
            2'b11:   lock_thr = LOCK_THR3;
            default: lock_thr = 8'hFF;
        endcase
    end
    assign lock_hit = startup_i && lock_code != 2'b00 && angle_err_i > lock_thr;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            lock_o <= 1'b0;
        end else if (lock_hit) begin
            lock_o <= 1'b1;
        end else if (restart_i) begin
            lock_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            speed_demand_o <= '0;
        end else if (cfg_r[IDX_SPEED][BIT_SPD_REG]) begin
            speed_demand_o <= cfg_r[IDX_SPEED][SPD_W-1:0];
        end else begin
            speed_demand_o <= spd_pin_i;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_wr(logic [7:0] a);
        reg_we_i && reg_addr_i == a;
    endsequence

    property p_direct;
        s_wr(ADDR_STARTUP) |=> advance_direct_o == $past(reg_wdata_i[BIT_DIRECT_ADV]);
    endproperty
    a_direct: assert property (p_direct) else $error("direct advance bit not applied");

    property p_shunt;
        s_wr(ADDR_SHUNT) |=> shunt_code_o == $past(reg_wdata_i[15:8]);
    endproperty
    a_shunt: assert property (p_shunt) else $error("shunt code not updated");

    property p_limit;
        reg_we_i && reg_addr_i == ADDR_STARTUP && !reg_wdata_i[BIT_LIMIT_EN]
            |=> !current_limit_o;
    endproperty
    a_limit: assert property (p_limit) else $error("limit active while disabled");

    property p_tune;
        s_wr(ADDR_OBSERVER) |=> tuning_window_o == $past(reg_wdata_i[BIT_TUNE_WIN]);
    endproperty
    a_tune: assert property (p_tune) else $error("tuning window not following write");

    property p_ramp;
        ramp_active_o && !soft_off_done_i && ramp_cnt_r == ramp_max - TMR_W'(1)
            |=> !ramp_active_o && ramp_timeout_o;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp ran past its cap");

    property p_brake;
        s_wr(ADDR_SOFTDT) |=> brake_mult_o == 4'h1 << $past(reg_wdata_i[15:14]);
    endproperty
    a_brake: assert property (p_brake) else $error("brake multiplier wrong");

    property p_oc_restart;
        oc_fault_o && !cfg_r[IDX_OCACCEL][BIT_OC_AUTO] && restart_i && !oc_hit
            |=> !oc_fault_o;
    endproperty
    a_oc_restart: assert property (p_oc_restart) else $error("fault not cleared on restart");

    sequence s_blank_long;
        blank_active_o [*8];
    endsequence
    property p_blank;
        gate_switch_i && blank_code == 2'b11
            |=> s_blank_long ##120 blank_active_o ##1 !blank_active_o;
    endproperty
    a_blank: assert property (p_blank) else $error("1280 ns blanking length wrong");

    property p_blank_mask;
        $rose(oc_fault_o) |-> $past(!blank_active_o && !gate_switch_i && oc_detect_i);
    endproperty
    a_blank_mask: assert property (p_blank_mask) else $error("fault set while blanked");

    property p_blank_len;
        gate_switch_i && blank_code == 2'b01
            |=> blank_active_o [*8] ##24 blank_active_o ##1 !blank_active_o;
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("320 ns blanking length wrong");

    property p_lock;
        lock_hit |=> lock_o;
    endproperty
    a_lock: assert property (p_lock) else $error("lock not declared");

    property p_speed;
        cfg_r[IDX_SPEED][BIT_SPD_REG] |=> speed_demand_o == $past(cfg_r[IDX_SPEED][8:0]);
    endproperty
    a_speed: assert property (p_speed) else $error("register speed demand not used");

    property p_speed_pin;
        !cfg_r[IDX_SPEED][BIT_SPD_REG] |=> speed_demand_o == $past(spd_pin_i);
    endproperty
    a_speed_pin: assert property (p_speed_pin) else $error("pin speed demand not used");

    property p_angle;
        s_wr(ADDR_OBSERVER) |=> advance_angle_o == $past(reg_wdata_i[IND_LSB +: IND_W]);
    endproperty
    a_angle: assert property (p_angle) else $error("advance angle not applied");

    property p_dtcomp;
        s_wr(ADDR_BRAKEMISC) |=> deadtime_comp_o == $past(reg_wdata_i[BIT_DT_COMP]);
    endproperty
    a_dtcomp: assert property (p_dtcomp) else $error("dead-time comp not applied");

    property p_ramp_done;
        ramp_active_o && soft_off_done_i |=> !ramp_active_o && !ramp_timeout_o;
    endproperty
    a_ramp_done: assert property (p_ramp_done) else $error("ramp did not end on done");

    property p_oc_set;
        oc_hit |=> oc_fault_o;
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("over-current hit not latched");

    property p_oc_auto;
        oc_fault_o && cfg_r[IDX_OCACCEL][BIT_OC_AUTO] && !oc_auto_clr |=> oc_fault_o;
    endproperty
    a_oc_auto: assert property (p_oc_auto) else $error("auto-mode fault cleared early");

    property p_blank_none;
        gate_switch_i && blank_code == 2'b00 |=> !blank_active_o;
    endproperty
    a_blank_none: assert property (p_blank_none) else $error("blanking with code zero");

    property p_lock_off;
        !lock_o && lock_code == 2'b00 |=> !lock_o;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock while detection off");

    property p_rvalid;
        reg_re_i |=> reg_rvalid_o;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
endmodule

// ### test/mdp_stage_model.sv
// power stage and motor stand-in for the drive configuration bench
`timescale 1ns/10ps
module mdp_stage_model (
    input  wire logic       clk_i,        // bench clock
    input  wire logic       ramp_i,       // soft shutdown ramping
    input  wire logic [7:0] done_dly_i,   // cycles to stop, 0 never
    input  wire logic       oc_req_i,     // bench asks for over-current
    output logic            done_o,       // ramp reached zero
    output logic            oc_o          // comparator output
);
    logic [7:0] cnt_r;
    // comparator answers a cycle late, like a real filter stage
    always_ff @(posedge clk_i) begin
        cnt_r <= ramp_i ? cnt_r + 8'h01 : 8'h00;
        oc_o  <= oc_req_i;
    end
    assign done_o = ramp_i && done_dly_i != 8'h00 && cnt_r >= done_dly_i;
endmodule

// ### test/mdp_top_tb.sv
// self-checking bench for the drive protection configuration decode
`timescale 1ns/10ps
module mdp_top_tb;
    import mdp_pkg::*;
    localparam int SHORT_C = 20;
    localparam int LONG_C  = 40;
    localparam int AUTO_C  = 50;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
        logic [3:0]  sel;
        logic [15:0] exp;
    } mdp_row_s;
    logic        sys_clk, reset, we, re, over_lim, startup, oc_req, rvalid, adv_dir;
    logic        cur_lim, tune, ramp, ramp_to, dt_comp, blank, fault, lock, done, oc;
    logic [2:0]  kick;
    logic [3:0]  brake;
    logic [4:0]  adv_ang;
    logic [7:0]  addr, angle, done_dly, shunt;
    logic [8:0]  spd_pin, speed;
    logic [15:0] wdata, rdata;
    int          err_total, num_checks, n;
    mdp_row_s    rows [18];
    logic [7:0]  thr [4] = '{8'hFE, 8'h05, 8'h09, 8'h0D};

    mdp_top #(.SOFT_SHORT(SHORT_C), .SOFT_LONG(LONG_C), .OC_AUTO(AUTO_C)) i_dut (
        .sys_clk_i(sys_clk), .reset_i(reset), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .advance_direct_o(adv_dir), .advance_angle_o(adv_ang), .shunt_code_o(shunt),
        .over_limit_i(over_lim), .current_limit_o(cur_lim), .tuning_window_o(tune),
        .soft_off_start_i(kick[0]), .soft_off_done_i(done), .ramp_active_o(ramp),
        .ramp_timeout_o(ramp_to), .deadtime_comp_o(dt_comp), .brake_mult_o(brake),
        .gate_switch_i(kick[1]), .oc_detect_i(oc), .restart_i(kick[2]),
        .blank_active_o(blank), .oc_fault_o(fault), .startup_i(startup),
        .angle_err_i(angle), .lock_o(lock), .spd_pin_i(spd_pin), .speed_demand_o(speed));
    mdp_stage_model i_stage (.clk_i(sys_clk), .ramp_i(ramp), .done_dly_i(done_dly),
        .oc_req_i(oc_req), .done_o(done), .oc_o(oc));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [15:0] out_of(input logic [3:0] s);
        case (s)
            4'h0: out_of = 16'(adv_dir);
            4'h1: out_of = 16'(adv_ang);
            4'h2: out_of = 16'(shunt);
            4'h3: out_of = 16'(cur_lim);
            4'h4: out_of = 16'(tune);
            4'h5: out_of = 16'(dt_comp);
            4'h6: out_of = 16'(brake);
            default: out_of = 16'(speed);
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge sys_clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge sys_clk);
        re <= 1'b0;
        #1;
        check(16'(rvalid), 16'h0001);
        check(rdata, d);
    endtask

    // kick bits: 0 soft-off start, 1 gate switch, 2 restart
    task automatic pulse(input int k);
        @(posedge sys_clk);
        kick[k] <= 1'b1;
        @(posedge sys_clk);
        kick <= 3'h0;
    endtask

    // cycles a level stays high: 0 ramp, 1 blank, 2 fault
    task automatic span(input int s, output int cnt);
        cnt = 0;
        #1;
        while ((s == 0 ? ramp : s == 1 ? blank : fault) === 1'b1 && cnt < 1000) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        if (cnt >= 1000) begin
            err_total++;
            complete_run();
        end
    endtask

    task automatic oc_hit;
        @(posedge sys_clk);
        oc_req <= 1'b1;
        @(posedge sys_clk);
        oc_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(16'(fault), 16'h0001);
    endtask

    initial begin
        {reset, we, re, over_lim, startup, oc_req, kick} = 9'h100;
        {addr, angle, done_dly, spd_pin, wdata} = '0;
        err_total = 0;
        num_checks = 0;
        rows = '{
            '{8'h0B, 16'h0020, 4'h0, 16'h0001}, '{8'h0C, 16'h1700, 4'h1, 16'h0017},
            '{8'h0C, 16'h1700, 4'h4, 16'h0000}, '{8'h0C, 16'h8000, 4'h4, 16'h0001},
            '{8'h0C, 16'h8000, 4'h1, 16'h0000}, '{8'h14, 16'hB9A5, 4'h2, 16'h00B9},
            '{8'h0B, 16'h0080, 4'h3, 16'h0001}, '{8'h0B, 16'h7F7F, 4'h3, 16'h0000},
            '{8'h0B, 16'h7F7F, 4'h0, 16'h0001}, '{8'h16, 16'h1000, 4'h5, 16'h0001},
            '{8'h16, 16'hEFFF, 4'h5, 16'h0000}, '{8'h0F, 16'h0000, 4'h6, 16'h0001},
            '{8'h0F, 16'h4000, 4'h6, 16'h0002}, '{8'h0F, 16'h8000, 4'h6, 16'h0004},
            '{8'h0F, 16'hC000, 4'h6, 16'h0008}, '{8'h11, 16'h0000, 4'h7, 16'h00AB},
            '{8'h11, 16'h03C5, 4'h7, 16'h01C5}, '{8'h11, 16'hFC5A, 4'h7, 16'h00AB}
        };
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        check(16'(brake), 16'h0001);
        check(16'({fault, lock, ramp, blank, adv_dir, tune, dt_comp}), 16'h0000);
        @(posedge sys_clk);
        over_lim <= 1'b1;
        spd_pin  <= 9'h0AB;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].data);
            repeat (2) @(posedge sys_clk);
            #1;
            check(out_of(rows[i].sel), rows[i].exp);
        end
        $display("table done");
        rd(8'h14, 16'hB9A5);
        rd(8'h11, 16'hFC5A);
        wr(8'h20, 16'hFFFF);
        rd(8'h20, 16'h0000);
        $display("readback done");
        wr(8'h16, 16'h0000);
        pulse(0);
        span(0, n);
        check(16'(n), 16'(SHORT_C));
        check(16'(ramp_to), 16'h0001);
        wr(8'h16, 16'h0200);
        pulse(0);
        pulse(0);
        span(0, n);
        check(16'(n), 16'(LONG_C - 2));
        @(posedge sys_clk);
        done_dly <= 8'h05;
        pulse(0);
        span(0, n);
        check(16'({ramp_to, n < SHORT_C}), 16'h0001);
        $display("soft-off done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h10, 16'(c << 4));
            pulse(1);
            span(1, n);
            check(16'(n), c == 0 ? 16'h0000 : 16'(16 << c));
        end
        wr(8'h10, 16'h0010);
        pulse(1);
        @(posedge sys_clk);
        oc_req <= 1'b1;
        repeat (10) @(posedge sys_clk);
        oc_req <= 1'b0;
        span(1, n);
        check(16'(fault), 16'h0000);
        oc_hit();
        rd(8'h7F, 16'h8000);
        pulse(2);
        #1;
        check(16'(fault), 16'h0000);
        wr(8'h10, 16'h0008);
        oc_hit();
        pulse(2);
        #1;
        check(16'(fault), 16'h0001);
        span(2, n);
        check(16'(n > AUTO_C - 8 && n <= AUTO_C), 16'h0001);
        $display("fault done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h0F, 16'(c << 2));
            @(posedge sys_clk);
            startup <= 1'b1;
            angle   <= thr[c];
            repeat (3) @(posedge sys_clk);
            #1;
            check(16'(lock), 16'h0000);
            @(posedge sys_clk);
            angle <= thr[c] + 8'h01;
            repeat (3) @(posedge sys_clk);
            #1;
            check(16'(lock), 16'(c != 0));
            if (c == 3)
                rd(8'h7F, 16'h4000);
            @(posedge sys_clk);
            angle <= 8'h00;
            pulse(2);
            #1;
            check(16'(lock), 16'h0000);
        end
        $display("lock done");
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        check(16'({adv_dir, tune, dt_comp, shunt}), 16'h0000);
        check(16'(speed), 16'h0000);
        check(rdata, 16'h0000);
        @(posedge sys_clk);
        #1;
        check(16'(speed), 16'h00AB);
        $display("reset done");
        complete_run();
    end
endmodule
